// >>> sdwd_host.sv
/*
  Host model: an AXI4-Lite master that runs one write or one read at a time.
  Assumes the caller waits for reset release before its first call.
*/
`timescale 1ns/1ps
`default_nettype none
module sdwd_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // Handshakes are judged on what stands at the rising edge, where the slave samples too
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        b = bvalid;
        r = bresp;
      end
      bready <= 1'b0;
    end
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        v = rvalid;
        d = rdata;
        r = rresp;
      end
      rready <= 1'b0;
    end
  endtask : rd
endmodule : sdwd_host
`default_nettype wire

// >>> sdwd_pkg.sv
/*
  Package for the synthesizer programming-word decoder: bus offsets,
  word field positions, select codes and reset values.
  Assumes a 32-bit AXI4-Lite register bus and a single clock.
*/
package sdwd_pkg;

  // AXI4-Lite byte offsets
  localparam logic [7:0] SDWD_OFF_WORD    = 8'h00;  // Programming word in
  localparam logic [7:0] SDWD_OFF_FBDIV   = 8'h04;  // Feedback word readback
  localparam logic [7:0] SDWD_OFF_REFDIV  = 8'h08;
  localparam logic [7:0] SDWD_OFF_CTRL    = 8'h0C;
  localparam logic [7:0] SDWD_OFF_NSPUR   = 8'h10;
  localparam logic [7:0] SDWD_OFF_STATUS  = 8'h14;

  localparam int SDWD_WORD_W = 24;

  // Register select codes, bits [1:0] of every word
  typedef enum logic [1:0] {
    SDWD_SEL_FBDIV  = 2'h0,
    SDWD_SEL_REFDIV = 2'h1,
    SDWD_SEL_CTRL   = 2'h2,
    SDWD_SEL_NSPUR  = 2'h3
  } sdwd_sel_e;

  // Feedback divider word fields
  localparam int SDWD_FRACTIONAL_NUMERATOR_LSB = 2;
  localparam int SDWD_FRACTIONAL_NUMERATOR_W   = 12;
  localparam int SDWD_INT_LSB  = 14;
  localparam int SDWD_INT_W    = 9;
  localparam int SDWD_RLOCK_BIT = 23;

  // Reference divider word fields
  localparam int SDWD_MOD_LSB  = 2;
  localparam int SDWD_MOD_W    = 12;
  localparam int SDWD_MUX_LSB  = 20;
  localparam int SDWD_MUX_W    = 3;
  localparam logic [2:0] SDWD_MUX_RLOCK_SW = 3'h6;

  // Control word fields
  localparam int SDWD_CP_LSB = 7;
  localparam int SDWD_CP_W   = 4;
  localparam logic [3:0] SDWD_CP_MAX = 4'hF;

  // AXI responses
  localparam logic [1:0] SDWD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SDWD_RESP_SLVERR = 2'h2;

  localparam logic [23:0] SDWD_WORD_RST = 24'h00_0000;

endpackage : sdwd_pkg

// >>> sdwd_top.sv
/*
  Programming-word register bank of a fractional-N synthesizer, reached
  over AXI4-Lite. Software writes whole words to one port; the low two
  bits pick the target register. Outputs feed the divider and charge pump.
  Assumes one 20 MHz clock and a synchronous active-low reset.
*/
// Overview of operation
// (R1) Select bits 00 load the feedback divider word.
// (R2) Select bits 01 load the reference divider word.
// (R3) Select bits 10 load the control word.
// (R4) Select bits 11 load the noise and spur word.
// (R5) Nine-bit integer value from the feedback word drives the divide factor.
// (R6) Twelve-bit fractional numerator from the feedback word goes to interpolator.
// (R7) Host keeps numerator at or below the loaded modulus.
// (R8) Rapid-lock bit one forces charge-pump current to maximum.
// (R9) Rapid-lock bit zero uses the control word's current setting.
// (R10) Monitor pin in switch mode pulls low with rapid-lock, else floats.
// (R11) New modulus takes effect only at the next feedback word write.
// (R12) Select is decoded from the two low bits before other fields.
`timescale 1ns/1ps
`default_nettype none
module sdwd_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Synthesizer controls
  output logic [8:0]       int_value,
  output logic [11:0]      fractional_numerator,
  output logic [11:0]      fractional_modulus,
  output logic [3:0]       cp_current,
  output logic             rapid_lock,
  // Monitor pin, open drain
  output logic             monitor_pin_o,
  output logic             monitor_pin_oe
);

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        aw_got;
    logic        w_got;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [23:0] fbdiv;
    logic [23:0] refdiv;
    logic [23:0] ctrl;
    logic [23:0] nspur;
    logic [11:0] mod_active;
    logic        wr_ok;
    logic [3:0]  cp_cur;
    logic        mon_oe;
  } sdwd_state_s;

  sdwd_state_s s_q, s_d;

  logic ld_fbdiv, ld_refdiv, ld_ctrl, ld_nspur;
  logic word_valid;
  logic [23:0] word;

  assign word       = s_q.wdata[sdwd_pkg::SDWD_WORD_W-1:0];
  assign word_valid = s_q.aw_got && s_q.w_got && !s_q.bvalid
                      && (s_q.awaddr == sdwd_pkg::SDWD_OFF_WORD)
                      && s_q.wr_ok;

  sdwd_word_decode u_dec (
    .sel_bits   (word[1:0]),
    .word_valid (word_valid),
    .ld_fbdiv   (ld_fbdiv),
    .ld_refdiv  (ld_refdiv),
    .ld_ctrl    (ld_ctrl),
    .ld_nspur   (ld_nspur)
  );

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input sdwd_state_s s);
    case (a)
      sdwd_pkg::SDWD_OFF_FBDIV:  rd_mux = {8'h00, s.fbdiv};
      sdwd_pkg::SDWD_OFF_REFDIV: rd_mux = {8'h00, s.refdiv};
      sdwd_pkg::SDWD_OFF_CTRL:   rd_mux = {8'h00, s.ctrl};
      sdwd_pkg::SDWD_OFF_NSPUR:  rd_mux = {8'h00, s.nspur};
      sdwd_pkg::SDWD_OFF_STATUS: rd_mux = {15'h0000, s.mon_oe, s.cp_cur, s.mod_active};
      default:                   rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  function automatic logic rd_hit(input logic [7:0] a);
    rd_hit = (a == sdwd_pkg::SDWD_OFF_FBDIV)  || (a == sdwd_pkg::SDWD_OFF_REFDIV) ||
             (a == sdwd_pkg::SDWD_OFF_CTRL)   || (a == sdwd_pkg::SDWD_OFF_NSPUR)  ||
             (a == sdwd_pkg::SDWD_OFF_STATUS);
  endfunction : rd_hit

  logic        rlock_n;
  logic [3:0]  ctrl_cp_n;
  logic [2:0]  mux_n;

  always_comb begin
    s_d = s_q;
    // Write channel: take address and data in either order
    s_d.awready = !s_q.aw_got && !s_q.awready && !s_q.bvalid;
    s_d.wready  = !s_q.w_got && !s_q.wready && !s_q.bvalid;
    if (s_axi_awvalid && s_q.awready) begin
      s_d.awaddr  = s_axi_awaddr;
      s_d.aw_got  = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.wdata  = s_axi_wdata;
      s_d.wr_ok  = &s_axi_wstrb[2:0];
      s_d.w_got  = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      // Partial words are refused: a word must arrive whole
      s_d.bresp  = (s_q.awaddr == sdwd_pkg::SDWD_OFF_WORD && s_q.wr_ok)
                   ? sdwd_pkg::SDWD_RESP_OKAY : sdwd_pkg::SDWD_RESP_SLVERR;
      if (ld_fbdiv) begin
        s_d.fbdiv      = word;                                       // see R1
        s_d.mod_active = s_q.refdiv[sdwd_pkg::SDWD_MOD_LSB +: sdwd_pkg::SDWD_MOD_W]; // see R11
      end
      if (ld_refdiv) s_d.refdiv = word;                              // see R2
      if (ld_ctrl)   s_d.ctrl   = word;                              // see R3
      if (ld_nspur)  s_d.nspur  = word;                              // see R4
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
    end
    // Read channel
    s_d.arready = !s_q.arready && !s_q.rvalid;
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rd_mux(s_axi_araddr, s_q);
      s_d.rresp   = rd_hit(s_axi_araddr) ? sdwd_pkg::SDWD_RESP_OKAY
                                         : sdwd_pkg::SDWD_RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    // Derived from the next state so they change on the same edge as the words
    rlock_n   = s_d.fbdiv[sdwd_pkg::SDWD_RLOCK_BIT];
    ctrl_cp_n = s_d.ctrl[sdwd_pkg::SDWD_CP_LSB +: sdwd_pkg::SDWD_CP_W];
    mux_n     = s_d.refdiv[sdwd_pkg::SDWD_MUX_LSB +: sdwd_pkg::SDWD_MUX_W];
    s_d.cp_cur = rlock_n ? sdwd_pkg::SDWD_CP_MAX : ctrl_cp_n;       // see R8, see R9
    s_d.mon_oe = (mux_n == sdwd_pkg::SDWD_MUX_RLOCK_SW) && rlock_n;  // see R10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready  = s_q.awready;
  assign s_axi_wready   = s_q.wready;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = s_q.arready;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign int_value      = s_q.fbdiv[sdwd_pkg::SDWD_INT_LSB +: sdwd_pkg::SDWD_INT_W];   // see R5
  // Numerator above modulus is the host's fault and is passed on unchecked (see R7)
  assign fractional_numerator = s_q.fbdiv[sdwd_pkg::SDWD_FRACTIONAL_NUMERATOR_LSB +: sdwd_pkg::SDWD_FRACTIONAL_NUMERATOR_W]; // see R6
  assign fractional_modulus   = s_q.mod_active;
  assign rapid_lock     = s_q.fbdiv[sdwd_pkg::SDWD_RLOCK_BIT];
  assign cp_current     = s_q.cp_cur;
  // Open drain: only ever drives low
  assign monitor_pin_o  = 1'b0;
  assign monitor_pin_oe = s_q.mon_oe;

  chk_rlock_cp_max: assert property (@(posedge aclk) disable iff (!aresetn)
    rapid_lock |-> cp_current == sdwd_pkg::SDWD_CP_MAX)  // see R8
    else $error("cp current not max under rapid lock");
  chk_cp_from_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
    !rapid_lock |-> cp_current == s_q.ctrl[sdwd_pkg::SDWD_CP_LSB +: sdwd_pkg::SDWD_CP_W]) // see R9
    else $error("cp current not from control word");
  chk_mon_pull: assert property (@(posedge aclk) disable iff (!aresetn)
    monitor_pin_oe == (rapid_lock &&
      s_q.refdiv[sdwd_pkg::SDWD_MUX_LSB +: sdwd_pkg::SDWD_MUX_W] == sdwd_pkg::SDWD_MUX_RLOCK_SW))
    else $error("monitor pin drive mismatch");  // see R10
  chk_fb_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_fbdiv |=> s_q.fbdiv == $past(word))  // see R1
    else $error("feedback word not loaded");
  chk_ref_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_refdiv |=> s_q.refdiv == $past(word) && $stable(s_q.fbdiv))  // see R2
    else $error("reference word not loaded");
  chk_ctrl_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_ctrl |=> s_q.ctrl == $past(word))  // see R3
    else $error("control word not loaded");
  chk_nspur_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_nspur |=> s_q.nspur == $past(word))  // see R4
    else $error("noise word not loaded");
  chk_mod_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !ld_fbdiv |=> $stable(fractional_modulus))  // see R11
    else $error("modulus changed without feedback write");
  chk_int_field: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_fbdiv |=> int_value == $past(word[sdwd_pkg::SDWD_INT_LSB +: sdwd_pkg::SDWD_INT_W]))  // see R5
    else $error("integer value wrong");

endmodule : sdwd_top
`default_nettype wire

// >>> sdwd_word_decode.sv
/*
  Decodes one programming word into one-hot load strobes.
  Assumes word_valid is a one-cycle pulse in the aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sdwd_word_decode (
  // Word in
  input  wire logic [1:0] sel_bits,
  input  wire logic       word_valid,
  // Strobes
  output logic            ld_fbdiv,
  output logic            ld_refdiv,
  output logic            ld_ctrl,
  output logic            ld_nspur
);
  // Select is decided from bits [1:0] alone before any field is used (see R12)
  always_comb begin
    ld_fbdiv  = word_valid && (sel_bits == sdwd_pkg::SDWD_SEL_FBDIV);   // see R1
    ld_refdiv = word_valid && (sel_bits == sdwd_pkg::SDWD_SEL_REFDIV);  // see R2
    ld_ctrl   = word_valid && (sel_bits == sdwd_pkg::SDWD_SEL_CTRL);    // see R3
    ld_nspur  = word_valid && (sel_bits == sdwd_pkg::SDWD_SEL_NSPUR);   // see R4
  end
endmodule : sdwd_word_decode
`default_nettype wire

// >>> synth_divider_word_decode_test.sv
/*
  Testbench: programs words through the host model and checks outputs.
  Assumes outputs settle two cycles after the write response.
*/
`timescale 1ns/1ps
`default_nettype none
module synth_divider_word_decode_test;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rapid_lock, mon_o, mon_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb, cp_current;
  logic [1:0]  bresp, rresp, resp;
  logic [8:0]  int_value;
  logic [11:0] fractional_numerator_num, fractional_numerator_mod;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Reference words: modulus 0x155, monitor in switch mode or not
  localparam logic [23:0] REF_SW = 24'h60_0555;
  localparam logic [23:0] REF_NS = 24'h00_0555;
  localparam logic [23:0] CTL_W  = 24'h00_0282;
  localparam logic [23:0] NSP_W  = 24'h00_03C7;
  localparam logic [23:0] FB_RL  = 24'hE9_4400;
  localparam logic [23:0] FB_NRM = 24'h69_4554;

  sdwd_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .int_value(int_value),
    .fractional_numerator(fractional_numerator_num), .fractional_modulus(fractional_numerator_mod),
    .cp_current(cp_current), .rapid_lock(rapid_lock),
    .monitor_pin_o(mon_o), .monitor_pin_oe(mon_oe));

  sdwd_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk

  task put(input logic [23:0] w);
    begin
      i_host.wr(sdwd_pkg::SDWD_OFF_WORD, {8'h00, w}, resp);
      chk(32'(resp), 32'(sdwd_pkg::SDWD_RESP_OKAY));
      repeat (2) @(posedge aclk);
    end
  endtask : put

  task rb(input logic [7:0] a, input logic [31:0] exp);
    begin
      i_host.rd(a, rd_data, resp);
      chk(rd_data, exp);
    end
  endtask : rb

  task final_report;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask : final_report

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // A whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end

  initial begin
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'({int_value, cp_current, mon_oe}), 32'h0000_0000);
    put(REF_SW);
    rb(sdwd_pkg::SDWD_OFF_REFDIV, {8'h00, REF_SW});
    chk(32'(fractional_numerator_mod), 32'h0000_0000);
    put(CTL_W);
    rb(sdwd_pkg::SDWD_OFF_CTRL, {8'h00, CTL_W});
    chk(32'(cp_current), 32'h0000_0005);
    put(NSP_W);
    rb(sdwd_pkg::SDWD_OFF_NSPUR, {8'h00, NSP_W});
    chk(32'(int_value), 32'h0000_0000);
    put(FB_RL);
    rb(sdwd_pkg::SDWD_OFF_FBDIV, {8'h00, FB_RL});
    chk(32'(int_value), 32'h0000_01A5);
    chk(32'(fractional_numerator_num), 32'h0000_0100);
    chk(32'(fractional_numerator_mod), 32'h0000_0155);
    chk(32'({rapid_lock, cp_current}), 32'h0000_001F);
    chk(32'({mon_oe, mon_o}), 32'h0000_0002);
    rb(sdwd_pkg::SDWD_OFF_STATUS, 32'h0001_F155);
    put(FB_NRM);
    chk(32'(fractional_numerator_num), 32'h0000_0155);
    chk(32'({rapid_lock, cp_current}), 32'h0000_0005);
    chk(32'(mon_oe), 32'h0000_0000);
    put(REF_NS);
    put(FB_RL);
    chk(32'({mon_oe, cp_current}), 32'h0000_000F);
    // Refused accesses must leave the loaded state alone
    i_host.wr(sdwd_pkg::SDWD_OFF_FBDIV, 32'h0000_0000, resp);
    chk(32'(resp), 32'(sdwd_pkg::SDWD_RESP_SLVERR));
    repeat (2) @(posedge aclk);
    chk(32'(int_value), 32'h0000_01A5);
    i_host.rd(8'h18, rd_data, resp);
    chk({resp, rd_data[29:0]}, {sdwd_pkg::SDWD_RESP_SLVERR, 30'h0000_0000});
    final_report;
  end
endmodule : synth_divider_word_decode_test
`default_nettype wire
